// *** pkg/supervisor_pkg.sv ***
// Constants and types for the supply supervisor with write guard
// Functional notes
// - Undervoltage asserts both reset outputs
// - Hold reset for timeout after supply recovers
// - Manual clear low asserts reset
// - Hold while low, plus full timeout after
// - Debounce the manual clear input
// - Unconnected manual clear reads high
// - External low on reset pin starts reset
// - Reset pins are open drain only
// - Write lock high refuses all writes
// - Write lock low or open permits writes
// - Block writes below threshold and at power-up
// - 2 kbit array, 16 byte page buffer
// - I2C target up to 400 kHz
// - SDA only pulled low or released
// - Reduced build drops high reset, write lock
// - Busy programming: no address acknowledge
package supervisor_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_NS = 1000;
  localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
  localparam int RESET_TIMEOUT_MS = 200;
  localparam int RESET_TIMEOUT_TICKS = RESET_TIMEOUT_MS * 1000000 / TICK_NS;
  localparam int WRITE_CYCLE_MS = 5;
  localparam int WRITE_CYCLE_TICKS = WRITE_CYCLE_MS * 1000000 / TICK_NS;
  localparam int DEBOUNCE_NS = 1000;
  localparam int DEBOUNCE_CYCLES =
    (DEBOUNCE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DB_W = 8;
  localparam int TICK_W = 8;
  localparam int TIMER_W = 24;
  localparam int MEM_BYTES = 256;
  localparam int PAGE_BYTES = 16;
  localparam logic [3:0] DEV_TYPE = 4'ha;
  localparam logic UV_RESET_VAL = 1'b1;
  localparam logic MC_RESET_VAL = 1'b1;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_WORD,
    ST_WRITE,
    ST_READ
  } i2c_state_t;
endpackage

// *** pkg/cond_if.sv ***
// Conditioned supervisor inputs between conditioner and core
`timescale 1ns/1ps
interface cond_if;
  logic raw_uv;
  logic raw_mc_n;
  logic uv_sync;
  logic mc_clean_n;
  modport conditioner (input raw_uv, input raw_mc_n,
                       output uv_sync, output mc_clean_n);
  modport core (output raw_uv, output raw_mc_n,
                input uv_sync, input mc_clean_n);
endinterface

// *** logic/input_conditioner.sv ***
// Synchronizer for undervoltage and manual clear, debouncer for manual clear only
`timescale 1ns/1ps
module input_conditioner import supervisor_pkg::*; (
  input wire logic core_clk,
  input wire logic reset_n,
  cond_if.conditioner cif
);
  localparam logic [DB_W-1:0] DB_LAST = DB_W'(DEBOUNCE_CYCLES - 1);
  logic uv_meta_q, uv_sync_q, mc_meta_q, mc_sync_q, mc_clean_q;
  logic [DB_W-1:0] db_cnt_q;

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      uv_meta_q <= UV_RESET_VAL;
      uv_sync_q <= UV_RESET_VAL;
      mc_meta_q <= MC_RESET_VAL;
      mc_sync_q <= MC_RESET_VAL;
    end else begin
      uv_meta_q <= cif.raw_uv;
      uv_sync_q <= uv_meta_q;
      mc_meta_q <= cif.raw_mc_n;
      mc_sync_q <= mc_meta_q;
    end
  end

  // Accept a new level only after it stays stable
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      mc_clean_q <= MC_RESET_VAL;
      db_cnt_q <= '0;
    end else if (mc_sync_q == mc_clean_q) begin
      db_cnt_q <= '0;
    end else if (db_cnt_q == DB_LAST) begin
      mc_clean_q <= mc_sync_q;
      db_cnt_q <= '0;
    end else begin
      db_cnt_q <= db_cnt_q + 1'b1;
    end
  end

  assign cif.uv_sync = uv_sync_q;
  assign cif.mc_clean_n = mc_clean_q;

  a_debounce_stable: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (mc_clean_q != $past(mc_clean_q)) |->
      ($past(db_cnt_q) == DB_LAST && $past(mc_sync_q) == mc_clean_q))
    else $error("manual clear changed before debounce time");
endmodule

// *** logic/supply_supervisor_write_guard.sv ***
// Reset sequencer, write gating and I2C memory target
`timescale 1ns/1ps
module supply_supervisor_write_guard import supervisor_pkg::*; #(
  parameter int TIMEOUT_TICKS = RESET_TIMEOUT_TICKS,
  parameter int WRITE_TICKS = WRITE_CYCLE_TICKS,
  parameter bit FULL_BUILD = 1'b1
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic supply_low,
  input wire logic manual_clear_n,
  input wire logic write_lock,
  input wire logic rst_lo_i,
  output logic rst_lo_o,
  output logic rst_lo_oe_n,
  output logic rst_hi_o,
  output logic rst_hi_oe_n,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n
);
  localparam logic [TIMER_W-1:0] TO_LAST = TIMER_W'(TIMEOUT_TICKS - 1);
  localparam logic [TIMER_W-1:0] WR_LAST = TIMER_W'(WRITE_TICKS - 1);
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);

  cond_if cif ();
  input_conditioner u_cond (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .cif(cif)
  );
  assign cif.raw_uv = supply_low;
  assign cif.raw_mc_n = manual_clear_n;

  // Microsecond tick
  logic [TICK_W-1:0] tick_cnt_q;
  logic tick;
  assign tick = (tick_cnt_q == TICK_LAST);
  always_ff @(posedge core_clk) begin
    if (!reset_n || tick) begin
      tick_cnt_q <= '0;
    end else begin
      tick_cnt_q <= tick_cnt_q + 1'b1;
    end
  end

  // Reset sequencer
  logic assert_q, ext_low, cause;
  logic [TIMER_W-1:0] to_cnt_q;
  assign ext_low = !rst_lo_i && !assert_q;
  assign cause = cif.uv_sync || !cif.mc_clean_n || ext_low;
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      assert_q <= 1'b1;
      to_cnt_q <= '0;
    end else if (cause) begin
      assert_q <= 1'b1;
      to_cnt_q <= '0;
    end else if (assert_q && tick) begin
      if (to_cnt_q == TO_LAST) begin
        assert_q <= 1'b0;
      end else begin
        to_cnt_q <= to_cnt_q + 1'b1;
      end
    end
  end

  // Open-drain pins: pull to active level or release
  assign rst_lo_o = 1'b0;
  assign rst_lo_oe_n = !assert_q;
  assign rst_hi_o = 1'b1;
  assign rst_hi_oe_n = !(assert_q && FULL_BUILD);

  // Write gating
  logic seen_ok_q, write_ok;
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      seen_ok_q <= 1'b0;
    end else if (!cif.uv_sync) begin
      seen_ok_q <= 1'b1;
    end
  end
  // Pad pull-down makes an open lock pin read low
  assign write_ok = seen_ok_q && !cif.uv_sync
    && !(FULL_BUILD && write_lock);

  // I2C target, bus sampled at core clock rate
  i2c_state_t state_q;
  logic scl_q, sda_q, ack_phase_q, ack_ours_q, drive_q, pending_q;
  logic busy_q, commit;
  logic [3:0] bit_cnt_q;
  logic [7:0] shreg_q, tx_q, ptr_q;
  logic [TIMER_W-1:0] wr_cnt_q;
  logic [7:0] mem_q [MEM_BYTES];
  logic [7:0] pbuf_q [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] pvalid_q;
  logic scl_rise, scl_fall, start, stop, byte_done, addr_hit;

  assign scl_rise = scl_i && !scl_q;
  assign scl_fall = !scl_i && scl_q;
  assign start = scl_i && scl_q && sda_q && !sda_i;
  assign stop = scl_i && scl_q && !sda_q && sda_i;
  assign byte_done = scl_fall && !ack_phase_q && bit_cnt_q == 4'd8;
  assign addr_hit = shreg_q[7:4] == DEV_TYPE && !busy_q;
  assign commit = stop && pending_q && write_ok;

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_i;
      sda_q <= sda_i;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      state_q <= ST_IDLE;
      ack_phase_q <= 1'b0;
      ack_ours_q <= 1'b0;
      drive_q <= 1'b0;
      bit_cnt_q <= '0;
      shreg_q <= '0;
      tx_q <= '0;
      ptr_q <= '0;
      pending_q <= 1'b0;
      pvalid_q <= '0;
    end else if (start || stop) begin
      state_q <= start ? ST_ADDR : ST_IDLE;
      ack_phase_q <= 1'b0;
      drive_q <= 1'b0;
      bit_cnt_q <= '0;
      pending_q <= 1'b0;
    end else if (state_q != ST_IDLE) begin
      if (scl_rise && !ack_phase_q) begin
        shreg_q <= {shreg_q[6:0], sda_i};
        bit_cnt_q <= bit_cnt_q + 1'b1;
      end else if (scl_rise && !ack_ours_q && sda_i) begin
        state_q <= ST_IDLE; // Master ended the read
      end else if (byte_done) begin
        ack_phase_q <= 1'b1;
        bit_cnt_q <= '0;
        ack_ours_q <= state_q != ST_READ;
        drive_q <= state_q != ST_READ;
        case (state_q)
          ST_ADDR: begin
            if (!addr_hit) begin
              state_q <= ST_IDLE;
              drive_q <= 1'b0;
            end else if (shreg_q[0]) begin
              state_q <= ST_READ;
            end else begin
              state_q <= ST_WORD;
            end
          end
          ST_WORD: begin
            ptr_q <= shreg_q;
            pvalid_q <= '0;
            state_q <= ST_WRITE;
          end
          ST_WRITE: begin
            pbuf_q[ptr_q[3:0]] <= shreg_q;
            pvalid_q[ptr_q[3:0]] <= 1'b1;
            ptr_q <= {ptr_q[7:4], ptr_q[3:0] + 4'h1};
            pending_q <= 1'b1;
          end
          default: begin
          end
        endcase
      end else if (scl_fall && ack_phase_q) begin
        ack_phase_q <= 1'b0;
        drive_q <= 1'b0;
        if (state_q == ST_READ) begin
          tx_q <= mem_q[ptr_q];
          drive_q <= !mem_q[ptr_q][7];
          ptr_q <= ptr_q + 8'h01;
        end
      end else if (scl_fall && state_q == ST_READ && bit_cnt_q != 4'd0) begin
        tx_q <= {tx_q[6:0], 1'b0};
        drive_q <= !tx_q[6];
      end
    end
  end

  // Programming cycle
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      busy_q <= 1'b0;
      wr_cnt_q <= '0;
    end else if (commit) begin
      busy_q <= 1'b1;
      wr_cnt_q <= '0;
    end else if (busy_q && tick) begin
      if (wr_cnt_q == WR_LAST) begin
        busy_q <= 1'b0;
      end else begin
        wr_cnt_q <= wr_cnt_q + 1'b1;
      end
    end
  end

  for (genvar i = 0; i < MEM_BYTES; i++) begin : g_mem
    always_ff @(posedge core_clk) begin
      if (commit && pvalid_q[i % PAGE_BYTES]
          && ptr_q[7:4] == 4'(i / PAGE_BYTES)) begin
        mem_q[i] <= pbuf_q[i % PAGE_BYTES];
      end
    end
  end

  assign sda_o = 1'b0;
  assign sda_oe_n = !drive_q;

  a_uv_forces_reset: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    cif.uv_sync |=> !rst_lo_oe_n && (rst_hi_oe_n == !FULL_BUILD))
    else $error("undervoltage did not assert reset");
  a_timeout_release: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    $fell(assert_q) |-> $past(to_cnt_q) == TO_LAST && $past(tick)
      && !$past(cause))
    else $error("reset released before timeout");
  a_manual_holds: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    !cif.mc_clean_n |=> assert_q && to_cnt_q == '0)
    else $error("manual clear did not hold reset");
  a_ext_starts: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (!rst_lo_i && !assert_q) |=> assert_q [*2])
    else $error("forced reset pin not latched");
  a_pins_release: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    !assert_q |-> rst_lo_oe_n && rst_hi_oe_n)
    else $error("reset pin driven while inactive");
  a_lock_blocks: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (FULL_BUILD && write_lock) |-> !commit ##1 !$rose(busy_q))
    else $error("write committed while locked");
  a_powerup_blocks: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (!seen_ok_q || cif.uv_sync) |-> !commit)
    else $error("write committed below threshold");
  a_busy_nack: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (busy_q && byte_done && state_q == ST_ADDR) |=> !drive_q)
    else $error("address acknowledged while programming");
  a_sda_scl_low: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    $rose(drive_q) |-> !scl_i && !$past(scl_i))
    else $error("sda pulled low while scl high");
endmodule

// *** verif/mcu_model.sv ***
// Behavioural I2C master standing for the system microcontroller
`timescale 1ns/1ps
module mcu_model (
  input wire logic core_clk,
  input wire logic sda_w,
  output logic scl,
  output logic sda_m
);
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // Start or repeated start, data moves only while clock low
  task automatic start();
    sda_m <= 1'b1;
    cyc(80);
    scl <= 1'b1;
    cyc(70);
    sda_m <= 1'b0;
    cyc(70);
    scl <= 1'b0;
    cyc(90);
  endtask
  // Stop, then bus free time before the next start
  task automatic stop();
    sda_m <= 1'b0;
    cyc(80);
    scl <= 1'b1;
    cyc(70);
    sda_m <= 1'b1;
    cyc(140);
  endtask
  // One bit in 250 cycles, 400 kHz: low 170, high 80
  task automatic bit_x(input logic b, output logic r);
    sda_m <= b;
    cyc(80);
    scl <= 1'b1;
    cyc(80);
    r = sda_w;
    scl <= 1'b0;
    cyc(90);
  endtask
  task automatic wbyte(input logic [7:0] d, output logic a);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], r);
    end
    bit_x(1'b1, a);
  endtask
  task automatic rbyte(input logic nack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, r);
      d[i] = r;
    end
    bit_x(nack, r);
  endtask
endmodule

// *** verif/supply_supervisor_write_guard_tb.sv ***
// Self-checking bench for the supply supervisor with write guard
`timescale 1ns/1ps
module supply_supervisor_write_guard_tb;
  logic core_clk, reset_n, supply_low, manual_clear_n, write_lock, ext_lo;
  logic rst_lo_o, rst_lo_oe_n, rst_hi_o, rst_hi_oe_n, sda_o, sda_oe_n;
  logic scl, sda_m, red_hi_oe_n, red_lo_oe_n, ak;
  logic [7:0] d;
  int bad_count, tests_run;
  wire sda_w = sda_m & (sda_oe_n ? 1'b1 : sda_o);
  wire rst_lo_w = ~ext_lo & (rst_lo_oe_n ? 1'b1 : rst_lo_o);
  supply_supervisor_write_guard #(.TIMEOUT_TICKS(20), .WRITE_TICKS(30))
  u_dut (.core_clk(core_clk), .reset_n(reset_n), .supply_low(supply_low),
    .manual_clear_n(manual_clear_n), .write_lock(write_lock),
    .rst_lo_i(rst_lo_w), .rst_lo_o(rst_lo_o), .rst_lo_oe_n(rst_lo_oe_n),
    .rst_hi_o(rst_hi_o), .rst_hi_oe_n(rst_hi_oe_n), .scl_i(scl),
    .sda_i(sda_w), .sda_o(sda_o), .sda_oe_n(sda_oe_n));
  supply_supervisor_write_guard #(.TIMEOUT_TICKS(20), .WRITE_TICKS(10),
    .FULL_BUILD(1'b0))
  u_red (.core_clk(core_clk), .reset_n(reset_n), .supply_low(supply_low),
    .manual_clear_n(manual_clear_n), .write_lock(write_lock),
    .rst_lo_i(rst_lo_w), .rst_lo_o(), .rst_lo_oe_n(red_lo_oe_n),
    .rst_hi_o(), .rst_hi_oe_n(red_hi_oe_n), .scl_i(scl), .sda_i(sda_w),
    .sda_o(), .sda_oe_n());
  mcu_model u_mcu (.core_clk(core_clk), .sda_w(sda_w), .scl(scl),
    .sda_m(sda_m));
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e) begin
      $display("BAD %0t got %h want %h", $time, g, e);
      bad_count++;
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // Reset must stand about the timeout, then both pins let go
  // Spent: cycles already past since the timeout began
  task automatic wait_rel(input int spent);
    int n;
    n = spent;
    while (rst_lo_oe_n !== 1'b1 && n < 2500) begin
      tick(1);
      n++;
    end
    tests_run++;
    if (n < 1900 || n >= 2500) begin
      $display("BAD %0t release after %0d cycles", $time, n);
      bad_count++;
      finish_test();
    end else begin
      chk(rst_hi_oe_n, 1'b1);
    end
  endtask
  task automatic addr(input logic [7:0] a, input logic e);
    u_mcu.start();
    u_mcu.wbyte(a, ak);
    u_mcu.stop();
    chk(ak, e);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d0, d1);
    u_mcu.start();
    u_mcu.wbyte(8'ha0, ak);
    chk(ak, 1'b0);
    u_mcu.wbyte(a, ak);
    u_mcu.wbyte(d0, ak);
    u_mcu.wbyte(d1, ak);
    chk(ak, 1'b0);
    u_mcu.stop();
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    u_mcu.start();
    u_mcu.wbyte(8'ha0, ak);
    u_mcu.wbyte(a, ak);
    u_mcu.start();
    u_mcu.wbyte(8'ha1, ak);
    u_mcu.rbyte(1'b1, d);
    u_mcu.stop();
    chk(d, e);
  endtask
  task automatic t_supply();
    supply_low <= 1'b1;
    tick(4);
    chk(rst_lo_oe_n, 1'b0);
    chk(rst_hi_oe_n, 1'b0);
    chk(red_hi_oe_n, 1'b1);
    chk(red_lo_oe_n, 1'b0);
    chk(rst_hi_o, 1'b1);
    chk(rst_lo_o, 1'b0);
    tick(40);
    supply_low <= 1'b0;
    wait_rel(0);
  endtask
  task automatic t_button();
    manual_clear_n <= 1'b0;
    tick(50);
    manual_clear_n <= 1'b1;
    tick(200);
    chk(rst_lo_oe_n, 1'b1);
    manual_clear_n <= 1'b0;
    tick(300);
    chk(rst_lo_oe_n, 1'b0);
    manual_clear_n <= 1'b1;
    wait_rel(0);
  endtask
  task automatic t_ext();
    ext_lo <= 1'b1;
    tick(1);
    chk(rst_lo_oe_n, 1'b0);
    tick(4);
    ext_lo <= 1'b0;
    wait_rel(5);
  endtask
  task automatic t_mem();
    wr(8'h0f, 8'h11, 8'h22);
    addr(8'ha0, 1'b1);
    tick(600);
    addr(8'h50, 1'b1);
    rd(8'h0f, 8'h11);
    rd(8'h00, 8'h22);
    write_lock <= 1'b1;
    wr(8'h0f, 8'h77, 8'h78);
    addr(8'ha0, 1'b0);
    write_lock <= 1'b0;
    rd(8'h0f, 8'h11);
    supply_low <= 1'b1;
    wr(8'h00, 8'h99, 8'h9a);
    supply_low <= 1'b0;
    wait_rel(0);
    rd(8'h00, 8'h22);
  endtask
  initial begin
    bad_count = 0;
    tests_run = 0;
    reset_n = 1'b0;
    supply_low = 1'b0;
    manual_clear_n = 1'b1;
    write_lock = 1'b0;
    ext_lo = 1'b0;
    tick(8);
    reset_n <= 1'b1;
    tick(1);
    chk(rst_lo_oe_n, 1'b0);
    wait_rel(0);
    t_mem();
    t_supply();
    t_button();
    t_ext();
    finish_test();
  end
endmodule
